// file: common/pmw_defines.svh
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PMW_OFS_RESET_SOURCE 8'h00
`define PMW_OFS_POWER_CONTROL 8'h04
`define PMW_OFS_PERIPH_POWER 8'h08
`define PMW_OFS_IRQ_ENABLE 8'h0C
`define PMW_OFS_RESET_ENABLE 8'h10
`define PMW_OFS_CLOCK_CFG 8'h14
`define PMW_OFS_STATUS 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMW_BIT_POWER_ON_FLAG 4
`define PMW_BIT_BROWNOUT_FLAG 5
`define PMW_BIT_BOD_IRQ 4
`define PMW_BIT_BOD_OFF 5
`define PMW_BIT_CMP_PD 5
`define PMW_BIT_RTC_PD 7
`define PMW_BIT_GLOBAL_IRQ 7
`define PMW_BIT_WDT_CLK_SEL 0
`define PMW_BIT_OSC_CRYSTAL 1
`define PMW_BIT_RC_SYSCLK 2
`define PMW_BIT_RTC_EN 3
`define PMW_BIT_CMP_EN 4
`define PMW_BIT_RTC_ON_XTAL 5

// ----------------------------------------------------------------
// Wake sources, index into the source vector
// ----------------------------------------------------------------
`define PMW_SRC_EXT0 0
`define PMW_SRC_EXT1 1
`define PMW_SRC_BROWNOUT 2
`define PMW_SRC_KEYBOARD 3
`define PMW_SRC_RTC 4
`define PMW_SRC_WATCHDOG 5
`define PMW_SRC_COMPARATOR 6

// ----------------------------------------------------------------
// Mode codes, reset values and stability counts
// ----------------------------------------------------------------
`define PMW_MODE_NORMAL 2'h0
`define PMW_MODE_IDLE 2'h1
`define PMW_MODE_PDOWN 2'h2
`define PMW_MODE_TOTAL_PDOWN 2'h3
`define PMW_RST_REG8 8'h00
`define PMW_RST_CLOCK_CFG 8'h02
`define PMW_STAB_XTAL_CLKS 1024
`define PMW_STAB_RC_CLKS 256

`endif

// file: common/pmw_pkg.sv
package pmw_pkg;

  // ----------------------------------------------------------------
  // Power sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_PDOWN,
    ST_WAKE
  } pmw_state_t;

endpackage : pmw_pkg

// file: hdl/pmw_stab_counter.sv
`timescale 1ns/10ps

// Counts oscillator start-up clocks and pulses when stable
module pmw_stab_counter #(
  parameter int CW = 11
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic [CW-1:0] count_in,
  output logic busy_out,
  output logic done_out
);

  logic [CW-1:0] cnt_r;
  logic busy_r;
  logic done_r;

  // --------------------------------------------------------------
  // Down counter
  // --------------------------------------------------------------
  // Load on start, count down while busy, one-cycle done at the end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start_in) begin
        cnt_r <= count_in;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == CW'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

  assign busy_out = busy_r;
  assign done_out = done_r;

endmodule : pmw_stab_counter

// file: hdl/pmw_top.sv
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "pmw_defines.svh"

module pmw_top #(
  parameter int NSRC = 7,
  parameter int NRST = 3
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic POR_DET_IN,
  input wire logic BOD_DET_IN,
  input wire logic BROWNOUT_ENABLE_CFG_IN,
  input wire logic [NSRC-1:0] IRQ_REQ_IN,
  input wire logic [NRST-1:0] RST_REQ_IN,
  output logic CPU_RUN_OUT,
  output logic PERIPH_RUN_OUT,
  output logic OSC_EN_OUT,
  output logic RC_OSC_EN_OUT,
  output logic WDT_RUN_OUT,
  output logic CMP_RUN_OUT,
  output logic RTC_RUN_OUT,
  output logic BOD_EN_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pmw_pkg::pmw_state_t state_r;
  pmw_pkg::pmw_state_t state_nxt;
  logic [1:0] por_sync_r;
  logic [1:0] bod_sync_r;
  logic [1:0] bo_en_sync_r;
  logic por_seen_r;
  logic power_on_flag_r;
  logic brownout_flag_r;
  logic [1:0] power_mode_r;
  logic [1:0] pd_mode_r;
  logic [1:0] gp_flag_r;
  logic bo_irq_r;
  logic bo_off_r;
  logic [7:0] periph_power_r;
  logic [7:0] irq_enable_r;
  logic [NRST-1:0] rst_enable_r;
  logic [7:0] clock_cfg_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_fire;
  logic wr_lane0;
  logic por_rise;
  logic bo_en;
  logic bod_active;
  logic mode_wr;
  logic [NSRC-1:0] src_mask;
  logic wake_irq;
  logic wake_rst;
  logic wake;
  logic stab_start;
  logic stab_busy;
  logic stab_done;
  logic [10:0] stab_count;
  logic total_pd;
  logic in_pd;
  logic wdt_clk_sel;
  logic xtal_cfg;
  logic rc_sysclk;
  logic rtc_en;
  logic cmp_en;
  logic rtc_on_xtal;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Analog detectors and the configuration strap cross in here
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      por_sync_r <= 2'h0;
      bod_sync_r <= 2'h0;
      bo_en_sync_r <= 2'h0;
    end else begin
      por_sync_r <= {por_sync_r[0], POR_DET_IN};
      bod_sync_r <= {bod_sync_r[0], BOD_DET_IN};
      bo_en_sync_r <= {bo_en_sync_r[0], BROWNOUT_ENABLE_CFG_IN};
    end
  end

  // Edge detect on the synchronised power-on level only
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      por_seen_r <= 1'b0;
    end else begin
      por_seen_r <= por_sync_r[1];
    end
  end

  assign por_rise = por_sync_r[1] & ~por_seen_r;
  assign bo_en = bo_en_sync_r[1];

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Ack one cycle after the strobe, dropped the cycle after it rose
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= WB_CYC_IN & WB_STB_IN & ~ack_r;
    end
  end

  // Writes land at the edge the master samples ack
  assign wr_fire = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ack_r;
  assign wr_lane0 = wr_fire & WB_SEL_IN[0];

  // Read mux, unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (WB_ADR_IN)
      `PMW_OFS_RESET_SOURCE: begin
        rdata_nxt[`PMW_BIT_POWER_ON_FLAG] = power_on_flag_r;
        rdata_nxt[`PMW_BIT_BROWNOUT_FLAG] = brownout_flag_r;
      end
      `PMW_OFS_POWER_CONTROL: begin
        rdata_nxt[7:0] = {2'h0, bo_off_r, bo_irq_r, gp_flag_r, power_mode_r};
      end
      `PMW_OFS_PERIPH_POWER: begin
        rdata_nxt[7:0] = periph_power_r;
      end
      `PMW_OFS_IRQ_ENABLE: begin
        rdata_nxt[7:0] = irq_enable_r;
      end
      `PMW_OFS_RESET_ENABLE: begin
        rdata_nxt[NRST-1:0] = rst_enable_r;
      end
      `PMW_OFS_CLOCK_CFG: begin
        rdata_nxt[7:0] = clock_cfg_r;
      end
      `PMW_OFS_STATUS: begin
        rdata_nxt[7:0] = {stab_busy, BOD_EN_OUT, OSC_EN_OUT, CPU_RUN_OUT,
                          2'h0, state_r};
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured at the edge that raises ack
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdata_r <= 32'h0000_0000;
    end else if (WB_CYC_IN & WB_STB_IN & ~ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = rdata_r;

  // ----------------------------------------------------------------
  // Reset source flags
  // ----------------------------------------------------------------
  // Detection active unless unconfigured, powered down or total mode
  assign bod_active = bo_en & ~bo_off_r & (pd_mode_r != `PMW_MODE_TOTAL_PDOWN);

  // Power-on flag: a set in the same cycle beats a software clear
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      power_on_flag_r <= 1'b0;
    end else if (por_rise) begin
      power_on_flag_r <= 1'b1;
    end else if (wr_lane0 && WB_ADR_IN == `PMW_OFS_RESET_SOURCE &&
                 !WB_DAT_IN[`PMW_BIT_POWER_ON_FLAG]) begin
      power_on_flag_r <= 1'b0;
    end
  end

  // Brownout flag follows power-on only when brownout is configured
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      brownout_flag_r <= 1'b0;
    end else if ((por_rise & bo_en) | (bod_sync_r[1] & bod_active)) begin
      brownout_flag_r <= 1'b1;
    end else if (wr_lane0 && WB_ADR_IN == `PMW_OFS_RESET_SOURCE &&
                 !WB_DAT_IN[`PMW_BIT_BROWNOUT_FLAG]) begin
      brownout_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power control register
  // ----------------------------------------------------------------
  assign mode_wr = wr_lane0 && WB_ADR_IN == `PMW_OFS_POWER_CONTROL;

  // Mode field returns to normal once a wake is taken
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      power_mode_r <= `PMW_MODE_NORMAL;
      gp_flag_r <= 2'h0;
      bo_irq_r <= 1'b0;
      bo_off_r <= 1'b0;
    end else begin
      if (wake && state_r != pmw_pkg::ST_RUN) begin
        power_mode_r <= `PMW_MODE_NORMAL;
      end else if (mode_wr) begin
        power_mode_r <= WB_DAT_IN[1:0];
      end
      if (mode_wr) begin
        gp_flag_r <= WB_DAT_IN[3:2];
        bo_irq_r <= WB_DAT_IN[`PMW_BIT_BOD_IRQ];
        bo_off_r <= WB_DAT_IN[`PMW_BIT_BOD_OFF];
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      periph_power_r <= `PMW_RST_REG8;
      irq_enable_r <= `PMW_RST_REG8;
      rst_enable_r <= '1;
      clock_cfg_r <= `PMW_RST_CLOCK_CFG;
    end else if (wr_lane0) begin
      case (WB_ADR_IN)
        `PMW_OFS_PERIPH_POWER: periph_power_r <= WB_DAT_IN[7:0];
        `PMW_OFS_IRQ_ENABLE: irq_enable_r <= WB_DAT_IN[7:0];
        `PMW_OFS_RESET_ENABLE: rst_enable_r <= WB_DAT_IN[NRST-1:0];
        `PMW_OFS_CLOCK_CFG: clock_cfg_r <= WB_DAT_IN[7:0];
        default: begin
        end
      endcase
    end
  end

  assign wdt_clk_sel = clock_cfg_r[`PMW_BIT_WDT_CLK_SEL];
  assign xtal_cfg = clock_cfg_r[`PMW_BIT_OSC_CRYSTAL];
  assign rc_sysclk = clock_cfg_r[`PMW_BIT_RC_SYSCLK];
  assign rtc_en = clock_cfg_r[`PMW_BIT_RTC_EN];
  assign cmp_en = clock_cfg_r[`PMW_BIT_CMP_EN];
  assign rtc_on_xtal = clock_cfg_r[`PMW_BIT_RTC_ON_XTAL];

  // ----------------------------------------------------------------
  // Wake decision
  // ----------------------------------------------------------------
  // Total power-down cannot wake from brownout or comparator sources
  always_comb begin
    src_mask = '1;
    if (pd_mode_r == `PMW_MODE_TOTAL_PDOWN) begin
      src_mask[`PMW_SRC_BROWNOUT] = 1'b0;
      src_mask[`PMW_SRC_COMPARATOR] = 1'b0;
    end
  end

  // Interrupts need their own enable and the global enable
  assign wake_irq = irq_enable_r[`PMW_BIT_GLOBAL_IRQ] &
    (|(IRQ_REQ_IN & irq_enable_r[NSRC-1:0] & src_mask));
  assign wake_rst = |(RST_REQ_IN & rst_enable_r);
  assign wake = wake_irq | wake_rst;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state: idle returns directly, power-down waits for stability
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pmw_pkg::ST_RUN: begin
        if (mode_wr && WB_DAT_IN[1:0] == `PMW_MODE_IDLE) begin
          state_nxt = pmw_pkg::ST_IDLE;
        end else if (mode_wr && WB_DAT_IN[1]) begin
          state_nxt = pmw_pkg::ST_PDOWN;
        end
      end
      pmw_pkg::ST_IDLE: begin
        if (wake) begin
          state_nxt = pmw_pkg::ST_RUN;
        end
      end
      pmw_pkg::ST_PDOWN: begin
        if (wake) begin
          state_nxt = pmw_pkg::ST_WAKE;
        end
      end
      pmw_pkg::ST_WAKE: begin
        if (stab_done) begin
          state_nxt = pmw_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = pmw_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_r <= pmw_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power-down flavour latched on entry, cleared when running again
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pd_mode_r <= `PMW_MODE_NORMAL;
    end else if (state_r == pmw_pkg::ST_RUN && state_nxt != state_r) begin
      pd_mode_r <= WB_DAT_IN[1:0];
    end else if (state_nxt == pmw_pkg::ST_RUN) begin
      pd_mode_r <= `PMW_MODE_NORMAL;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator stability counter
  // ----------------------------------------------------------------
  assign stab_start = state_r == pmw_pkg::ST_PDOWN && wake;
  assign stab_count = xtal_cfg ? 11'(`PMW_STAB_XTAL_CLKS)
                               : 11'(`PMW_STAB_RC_CLKS);

  pmw_stab_counter #(
    .CW(11)
  ) u_stab (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .start_in(stab_start),
    .count_in(stab_count),
    .busy_out(stab_busy),
    .done_out(stab_done)
  );

  // ----------------------------------------------------------------
  // Registered power outputs
  // ----------------------------------------------------------------
  assign in_pd = state_nxt == pmw_pkg::ST_PDOWN;
  assign total_pd = in_pd &&
    ((state_r == pmw_pkg::ST_RUN) ? WB_DAT_IN[1:0] : pd_mode_r)
      == `PMW_MODE_TOTAL_PDOWN;

  // Each output follows the state about to be entered
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CPU_RUN_OUT <= 1'b1;
      PERIPH_RUN_OUT <= 1'b1;
      OSC_EN_OUT <= 1'b1;
      RC_OSC_EN_OUT <= 1'b1;
      WDT_RUN_OUT <= 1'b1;
      CMP_RUN_OUT <= 1'b1;
      RTC_RUN_OUT <= 1'b0;
      BOD_EN_OUT <= 1'b0;
    end else begin
      CPU_RUN_OUT <= state_nxt == pmw_pkg::ST_RUN;
      PERIPH_RUN_OUT <= ~in_pd;
      // Main oscillator stops, kept only for an RTC running on it
      OSC_EN_OUT <= ~in_pd |
        (rtc_en & rtc_on_xtal & ~periph_power_r[`PMW_BIT_RTC_PD]);
      RC_OSC_EN_OUT <= ~in_pd | (rc_sysclk & rtc_en);
      WDT_RUN_OUT <= ~in_pd | wdt_clk_sel;
      CMP_RUN_OUT <= ~in_pd |
        (~total_pd & ~(periph_power_r[`PMW_BIT_CMP_PD] & ~cmp_en));
      RTC_RUN_OUT <= rtc_en &
        (~in_pd | ~periph_power_r[`PMW_BIT_RTC_PD]);
      BOD_EN_OUT <= bo_en & ~bo_off_r & ~total_pd;
    end
  end

endmodule : pmw_top

// file: verification/pmw_src_model.sv
`timescale 1ns/10ps

// --------------------------------------------------------------
// Wake sources: requests stay pending until the core runs
// --------------------------------------------------------------
module pmw_src_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cpu_run_in,
  input wire logic [6:0] irq_set_in,
  input wire logic [2:0] rst_set_in,
  output logic [6:0] irq_req_out,
  output logic [2:0] rst_req_out
);
  // Peripheral interrupt levels, serviced once the core runs
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_req_out <= 7'h00;
    end else if (|irq_set_in) begin
      irq_req_out <= irq_req_out | irq_set_in;
    end else if (cpu_run_in) begin
      irq_req_out <= 7'h00;
    end
  end

  // Reset requests, the safe wake after lowering supply
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_req_out <= 3'h0;
    end else if (|rst_set_in) begin
      rst_req_out <= rst_req_out | rst_set_in;
    end else if (cpu_run_in) begin
      rst_req_out <= 3'h0;
    end
  end
endmodule : pmw_src_model

// file: verification/pmw_top_chk.sv
`timescale 1ns/10ps

// --------------------------------------------------------------
// Port checks of the power sequencer
// --------------------------------------------------------------
module pmw_top_chk (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic WB_ACK_OUT,
  input wire logic CPU_RUN_OUT,
  input wire logic PERIPH_RUN_OUT,
  input wire logic OSC_EN_OUT,
  input wire logic CMP_RUN_OUT,
  input wire logic RTC_RUN_OUT,
  input wire logic BOD_EN_OUT
);
  logic mw_w;
  logic stopped_r;
  logic [10:0] cnt_r;
  logic xtal_r;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  // Mode write taking effect while the core runs
  assign mw_w = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT &&
    WB_SEL_IN[0] && WB_ADR_IN == 8'h04 && CPU_RUN_OUT;

  // Remembers that the main oscillator was stopped
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      stopped_r <= 1'b0;
    end else if (CPU_RUN_OUT) begin
      stopped_r <= 1'b0;
    end else if (!OSC_EN_OUT) begin
      stopped_r <= 1'b1;
    end
  end

  // Follows the crystal choice written to the clock configuration
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      xtal_r <= 1'b1;
    end else if (WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT &&
                 WB_SEL_IN[0] && WB_ADR_IN == 8'h14) begin
      xtal_r <= WB_DAT_IN[1];
    end
  end

  // Counts clocks since the oscillator came back
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cnt_r <= 11'h000;
    end else if (CPU_RUN_OUT || !stopped_r) begin
      cnt_r <= 11'h000;
    end else if (OSC_EN_OUT) begin
      cnt_r <= cnt_r + 11'h001;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  idle_entry_a: assert property (
    mw_w && WB_DAT_IN[1:0] == 2'h1 |=>
    !CPU_RUN_OUT && PERIPH_RUN_OUT && OSC_EN_OUT)
    else $error("idle entry wrong");
  pdown_entry_a: assert property (
    mw_w && WB_DAT_IN[1] |=> !CPU_RUN_OUT && !PERIPH_RUN_OUT)
    else $error("power-down entry wrong");
  osc_stop_a: assert property (
    $fell(PERIPH_RUN_OUT) && !RTC_RUN_OUT |-> !OSC_EN_OUT)
    else $error("oscillator kept in power-down");
  total_off_a: assert property (
    mw_w && WB_DAT_IN[1:0] == 2'h3 |=>
    ##[0:1] (!BOD_EN_OUT && !CMP_RUN_OUT))
    else $error("total power-down kept detector");
  bod_keep_a: assert property (
    mw_w && WB_DAT_IN[1:0] == 2'h2 && !WB_DAT_IN[5] && BOD_EN_OUT
    |=> BOD_EN_OUT [*4])
    else $error("brownout detect dropped");
  cpu_osc_a: assert property (
    !OSC_EN_OUT |-> !CPU_RUN_OUT)
    else $error("core runs without oscillator");
  stab_min_a: assert property (
    $rose(CPU_RUN_OUT) && stopped_r |->
    cnt_r >= (xtal_r ? 11'h400 : 11'h100))
    else $error("core resumed before stable");
  stab_max_a: assert property (
    cnt_r <= (xtal_r ? 11'h408 : 11'h108))
    else $error("stability wait too long");
endmodule : pmw_top_chk

bind pmw_top pmw_top_chk pmw_top_chk_inst (
  .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .WB_CYC_IN(WB_CYC_IN),
  .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
  .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_ACK_OUT(WB_ACK_OUT),
  .CPU_RUN_OUT(CPU_RUN_OUT), .PERIPH_RUN_OUT(PERIPH_RUN_OUT),
  .OSC_EN_OUT(OSC_EN_OUT), .CMP_RUN_OUT(CMP_RUN_OUT),
  .RTC_RUN_OUT(RTC_RUN_OUT), .BOD_EN_OUT(BOD_EN_OUT)
);

// file: verification/pmw_top_tb.sv
`timescale 1ns/10ps

// --------------------------------------------------------------
// Power mode and wake bench
// --------------------------------------------------------------
module pmw_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic por = 1'b0;
  logic bo_en = 1'b1;
  logic [6:0] irq_set = 7'h00;
  logic [2:0] rst_set = 3'h0;
  logic [6:0] irq_req;
  logic [2:0] rst_req;
  logic [31:0] rdat;
  logic ack, cpu, per, osc, rco, wdt, cmp, rtc, bod;
  int errors = 0;
  int checks = 0;

  // Clock
  always #5 clk = ~clk;

  pmw_top pmw_top_inst (
    .CLK_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'h1), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .POR_DET_IN(por),
    .BOD_DET_IN(1'b0), .BROWNOUT_ENABLE_CFG_IN(bo_en),
    .IRQ_REQ_IN(irq_req), .RST_REQ_IN(rst_req), .CPU_RUN_OUT(cpu),
    .PERIPH_RUN_OUT(per), .OSC_EN_OUT(osc), .RC_OSC_EN_OUT(rco),
    .WDT_RUN_OUT(wdt), .CMP_RUN_OUT(cmp), .RTC_RUN_OUT(rtc),
    .BOD_EN_OUT(bod)
  );

  pmw_src_model pmw_src_model_inst (
    .clk_in(clk), .rstn_in(rstn), .cpu_run_in(cpu),
    .irq_set_in(irq_set), .rst_set_in(rst_set),
    .irq_req_out(irq_req), .rst_req_out(rst_req)
  );

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 40) begin
      errors++;
      $display("[FAIL] bus ack expected 1 seen 0");
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {24'h000000, e}, q & {24'hFFFFFF, m});
  endtask : rd

  // One-cycle command to the wake source model
  task automatic pulse(input logic [6:0] iv, input logic [2:0] rv);
    @(posedge clk);
    irq_set <= iv;
    rst_set <= rv;
    @(posedge clk);
    irq_set <= 7'h00;
    rst_set <= 3'h0;
  endtask : pulse

  task automatic waitcpu(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpu !== 1'b1 && n < lim);
  endtask : waitcpu

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_flags;
    rd(8'h04, 8'hFF, 8'h00, "mode_reset");
    @(posedge clk);
    por <= 1'b1;
    repeat (6) @(posedge clk);
    por <= 1'b0;
    rd(8'h00, 8'h30, 8'h30, "flags_set");
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h30, 8'h30, "flags_keep");
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h30, 8'h00, "flags_clear");
  endtask : t_flags

  task automatic t_idle;
    int n;
    wr(8'h0C, 8'h81);
    wr(8'h04, 8'h01);
    @(negedge clk);
    chk("idle_run", 3'h3, {cpu, per, osc});
    rd(8'h18, 8'h03, 8'h01, "idle_state");
    pulse(7'h01, 3'h0);
    waitcpu(20, n);
    chk("idle_irq_wake", 1'h1, cpu);
    rd(8'h04, 8'h03, 8'h00, "mode_after");
    wr(8'h0C, 8'h01);
    wr(8'h04, 8'h01);
    pulse(7'h01, 3'h0);
    waitcpu(20, n);
    chk("no_global_wake", 1'h0, cpu);
    pulse(7'h00, 3'h1);
    waitcpu(20, n);
    chk("reset_wake", 1'h1, cpu);
  endtask : t_idle

  // Power-down: levels inside, refused wake, timed wake
  task automatic t_pd(input logic [7:0] cfg, input logic [7:0] pca,
    input logic [1:0] md, input logic [6:0] nw, input logic [6:0] w,
    input int cnt, input logic [5:0] e, input string nm);
    int n;
    wr(8'h14, cfg);
    wr(8'h08, pca);
    wr(8'h0C, 8'hFF);
    wr(8'h04, {6'h00, md});
    repeat (3) @(negedge clk);
    chk(nm, {26'h0, e}, {26'h0, osc, rco, wdt, cmp, rtc, bod});
    chk("pd_halt", 2'h0, {cpu, per});
    if (nw !== 7'h00) begin
      pulse(nw, 3'h0);
      waitcpu(40, n);
      chk("pd_refused", 1'h0, cpu);
    end
    pulse(w, 3'h0);
    repeat (5) @(negedge clk);
    chk("osc_restart", 1'h1, osc);
    waitcpu(1200, n);
    chk("stab_count", 1'h1, n + 6 >= cnt && n <= cnt + 12);
  endtask : t_pd

  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_flags;
    t_idle;
    t_pd(8'h02, 8'h00, 2'h2, 7'h00, 7'h01, 1024, 6'h05,
      "pd_xtal");
    t_pd(8'h0D, 8'h00, 2'h2, 7'h00, 7'h02, 256, 6'h1F,
      "pd_rc");
    t_pd(8'h0C, 8'hA0, 2'h2, 7'h00, 7'h08, 256, 6'h11,
      "pd_gated");
    t_pd(8'h2A, 8'h00, 2'h2, 7'h00, 7'h10, 1024, 6'h27,
      "pd_rtc");
    t_pd(8'h12, 8'h00, 2'h3, 7'h44, 7'h20, 1024, 6'h00,
      "pd_total");
    t_pd(8'h02, 8'h00, 2'h2, 7'h00, 7'h44, 1024, 6'h05,
      "pd_cmp");
    results;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[FAIL] run expected done seen timeout");
    results;
  end
endmodule : pmw_top_tb
